// ### differential_quadrature_counter.sv
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "dqc_map.svh"
module differential_quadrature_counter #(
  parameter int unsigned SLOW_CYC = `SLOW_CYC,
  parameter int unsigned PRIO_CYC = `PRIO_CYC,
  parameter int unsigned TB_CYC = `TB_CYC
)(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire dqc_pkg::axi_req_t axi_req_i,
  output dqc_pkg::axi_rsp_t axi_rsp_o,
  input wire logic plus_loop_phase_one_i,
  input wire logic plus_loop_phase_two_i,
  input wire logic minus_loop_phase_one_i,
  input wire logic minus_loop_phase_two_i,
  input wire logic count_inhibit_i,
  input wire logic home_enable_i,
  input wire logic index_pulse_i,
  input wire logic [2:0] capture_i,
  input wire logic [1:0] preload_i,
  output logic [3:0] preset_out_o
);
  localparam int NIN = 12;
  localparam logic [31:0] FAST_C = 32'(`FAST_CYC);

  // input order: plus a/b, minus a/b, inhibit, home en, index, capture x3, preload x2
  logic [NIN-1:0] raw, sync1, sync2, filt, filt_d, next_filt, slow_sel, rise, fall;
  logic [31:0] fcnt [NIN];
  logic [31:0] next_fcnt [NIN];
  logic [31:0] lim;

  dqc_pkg::axi_rsp_t rsp, next_rsp;
  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [7:0] waddr, next_waddr;
  logic [31:0] wdat, next_wdat, wval;
  logic [3:0] wstb, next_wstb;
  logic [31:0] ctrl, next_ctrl;
  logic [1:0] cmd, next_cmd;
  logic [6:0] clr, next_clr;
  logic wr_acc, next_wr_acc;
  logic [31:0] wr_val, next_wr_val;
  logic [31:0] pre_val [2];
  logic [31:0] next_pre_val [2];
  logic [31:0] home_pos, next_home_pos;
  logic [31:0] pset [8];
  logic [31:0] next_pset [8];
  logic [31:0] rd;
  logic rd_err;

  logic [31:0] acc, next_acc, cpt, next_cpt, run, next_run, tb, next_tb, sum, dext;
  logic [31:0] strb [3];
  logic [31:0] next_strb [3];
  logic [2:0] flg_cap, next_flg_cap, strb_ev;
  logic [1:0] flg_pre, next_flg_pre, pre_ev;
  logic home_found, next_home_found, err, next_err, ovf, ready;
  logic [3:0] out_r, next_out_r;
  logic home_done, next_home_done, home_ev, ld;
  logic [31:0] win_cnt, next_win_cnt, ld_val;
  logic [1:0] win_rank, next_win_rank;
  logic signed [1:0] sp, sm;
  logic signed [2:0] delta;

  function automatic logic signed [1:0] step(input logic [1:0] md, input logic a, b, ad, bd);
    logic signed [1:0] d;
    d = 2'sd0;
    case (dqc_pkg::count_mode_t'(md))
      dqc_pkg::MODE_UPDN:
        if ((a & ~ad) != (b & ~bd)) d = (a & ~ad) ? 2'sd1 : -2'sd1;
      dqc_pkg::MODE_PDIR:
        if (a & ~ad) d = b ? -2'sd1 : 2'sd1;
      dqc_pkg::MODE_QUAD:
        if ((a ^ ad) != (b ^ bd)) d = (a ^ bd) ? 2'sd1 : -2'sd1;
      default: d = 2'sd0;
    endcase
    return d;
  endfunction

  assign raw = {preload_i, capture_i, index_pulse_i, home_enable_i, count_inhibit_i,
                minus_loop_phase_two_i, minus_loop_phase_one_i,
                plus_loop_phase_two_i, plus_loop_phase_one_i};
  // home enable pinned slow, index and captures pinned fast
  assign slow_sel = {{2{ctrl[`CTL_FLT_PRE]}}, 4'h0, 1'b1, ctrl[`CTL_FLT_INH],
                     {2{ctrl[`CTL_FLT_M]}}, {2{ctrl[`CTL_FLT_P]}}};

  // a change passes only after it has held for the whole filter time
  always_comb
  begin
    lim = FAST_C;
    for (int i = 0; i < NIN; i++)
    begin
      next_filt[i] = filt[i];
      next_fcnt[i] = '0;
      lim = slow_sel[i] ? SLOW_CYC : FAST_C;
      if (sync2[i] != filt[i])
      begin
        if (fcnt[i] + 32'd1 >= lim)
          next_filt[i] = sync2[i];
        else
          next_fcnt[i] = fcnt[i] + 32'd1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
      filt <= '0;
      filt_d <= '0;
      fcnt <= '{default: '0};
    end
    else
    begin
      sync1 <= raw;
      sync2 <= sync1;
      filt <= next_filt;
      filt_d <= filt;
      fcnt <= next_fcnt;
    end
  end

  assign rise = filt & ~filt_d;
  assign fall = ~filt & filt_d;
  assign strb_ev = (ctrl[`CTL_POL+:3] & fall[9:7]) | (~ctrl[`CTL_POL+:3] & rise[9:7]);
  assign sp = step(ctrl[`CTL_PMODE+:2], filt[0], filt[1], filt_d[0], filt_d[1]);
  assign sm = step(ctrl[`CTL_MMODE+:2], filt[2], filt[3], filt_d[2], filt_d[3]);
  // minus loop enters with its sign turned over; inhibit level blocks all counts
  assign delta = filt[4] ? 3'sd0 :
                 $signed({sp[1], sp}) - $signed({sm[1], sm});
  assign dext = {{29{delta[2]}}, delta};
  assign sum = acc + dext;

  // home arms on the enable level while the home command bit is set and fires once on the next index edge
  assign home_ev = cmd[1] & filt[5] & rise[6] & ~home_done;
  // a lower-ranked load inside the window of a higher one is dropped
  assign pre_ev[0] = rise[10] & ~home_ev & (win_cnt == '0 || win_rank < 2'd2);
  assign pre_ev[1] = rise[11] & ~home_ev & ~pre_ev[0] & (win_cnt == '0 || win_rank < 2'd1);
  assign ld = home_ev | pre_ev[0] | pre_ev[1];
  assign ld_val = home_ev ? home_pos : (pre_ev[0] ? pre_val[0] : pre_val[1]);

  always_comb
  begin
    next_home_done = filt[5] & (home_done | home_ev);
    next_win_cnt = win_cnt;
    next_win_rank = win_rank;
    if (ld)
    begin
      next_win_cnt = PRIO_CYC - 32'd1;
      next_win_rank = home_ev ? 2'd3 : (pre_ev[0] ? 2'd2 : 2'd1);
    end
    else if (win_cnt != '0)
      next_win_cnt = win_cnt - 32'd1;
    else
      next_win_rank = 2'd0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      home_done <= 1'b0;
      win_cnt <= '0;
      win_rank <= 2'd0;
    end
    else
    begin
      home_done <= next_home_done;
      win_cnt <= next_win_cnt;
      win_rank <= next_win_rank;
    end
  end

  assign ovf = ~ld & ~wr_acc & (delta != 3'sd0) & (acc[31] == delta[2]) & (sum[31] != acc[31]);

  always_comb
  begin
    next_acc = sum;
    if (ld)
      next_acc = ld_val;
    else if (wr_acc)
      next_acc = wr_val;
    for (int i = 0; i < 3; i++)
      next_strb[i] = strb_ev[i] ? acc : strb[i];
    // set beats a clear arriving in the same cycle
    next_flg_cap = (flg_cap & ~clr[`CMD_CLR_CAP+:3]) | strb_ev;
    next_flg_pre = (flg_pre & ~clr[`CMD_CLR_PRE+:2]) | pre_ev;
    next_home_found = (home_found & ~clr[`CMD_CLR_HOME]) | home_ev;
    next_err = (err & ~clr[`CMD_CLR_ERR]) | ovf;
    next_tb = tb + 32'd1;
    next_run = run + dext;
    next_cpt = cpt;
    if (filt[4])
    begin
      next_run = '0;
      next_cpt = '0;
    end
    else if (tb >= TB_CYC - 32'd1)
    begin
      next_tb = '0;
      next_run = '0;
      next_cpt = run + dext;
    end
    for (int i = 0; i < 4; i++)
    begin
      if ($signed(pset[2*i]) <= $signed(pset[2*i+1]))
        next_out_r[i] = $signed(acc) >= $signed(pset[2*i]) &&
                        $signed(acc) < $signed(pset[2*i+1]);
      else
        next_out_r[i] = $signed(acc) >= $signed(pset[2*i]) ||
                        $signed(acc) < $signed(pset[2*i+1]);
      next_out_r[i] = next_out_r[i] & cmd[0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc <= `RST_WORD;
      strb <= '{default: '0};
      flg_cap <= '0;
      flg_pre <= '0;
      home_found <= 1'b0;
      err <= 1'b0;
      tb <= '0;
      run <= '0;
      cpt <= '0;
      out_r <= '0;
      ready <= 1'b0;
    end
    else
    begin
      acc <= next_acc;
      strb <= next_strb;
      flg_cap <= next_flg_cap;
      flg_pre <= next_flg_pre;
      home_found <= next_home_found;
      err <= next_err;
      tb <= next_tb;
      run <= next_run;
      cpt <= next_cpt;
      out_r <= next_out_r;
      ready <= 1'b1;
    end
  end

  assign preset_out_o = out_r;
  assign axi_rsp_o = rsp;

  // status and words that the controller polls each scan
  always_comb
  begin
    rd = '0;
    rd_err = 1'b0;
    if (axi_req_i.araddr[1:0] != 2'b00)
      rd_err = 1'b1;
    else if (axi_req_i.araddr == `OFF_CTRL)
      rd = ctrl;
    else if (axi_req_i.araddr == `OFF_CMD)
      rd = {23'h0, cmd, 7'h0};
    else if (axi_req_i.araddr == `OFF_STAT)
      rd = {18'h0, err, ready, out_r, filt[5], filt[4], home_found, flg_pre, flg_cap};
    else if (axi_req_i.araddr == `OFF_ACC)
      rd = acc;
    else if (axi_req_i.araddr == `OFF_CPT)
      rd = cpt;
    else if (axi_req_i.araddr >= `OFF_STRB0 && axi_req_i.araddr <= `OFF_STRB2)
      rd = strb[2'((axi_req_i.araddr - `OFF_STRB0) >> 2)];
    else if (axi_req_i.araddr == `OFF_PRE0 || axi_req_i.araddr == `OFF_PRE1)
      rd = pre_val[axi_req_i.araddr[2]];
    else if (axi_req_i.araddr == `OFF_HOME)
      rd = home_pos;
    else if (axi_req_i.araddr >= `OFF_PSET0 && axi_req_i.araddr <= `OFF_PSET7)
      rd = pset[3'((axi_req_i.araddr - `OFF_PSET0) >> 2)];
    else
      rd_err = 1'b1;
  end

  // write lanes not strobed keep their old bytes
  function automatic logic [31:0] merge(input logic [31:0] old, d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (s[b]) r[8*b+:8] = d[8*b+:8];
    return r;
  endfunction

  always_comb
  begin
    next_rsp = rsp;
    next_aw_got = aw_got | (axi_req_i.awvalid & rsp.awready);
    next_w_got = w_got | (axi_req_i.wvalid & rsp.wready);
    next_waddr = (axi_req_i.awvalid & rsp.awready) ? axi_req_i.awaddr : waddr;
    next_wdat = (axi_req_i.wvalid & rsp.wready) ? axi_req_i.wdata : wdat;
    next_wstb = (axi_req_i.wvalid & rsp.wready) ? axi_req_i.wstrb : wstb;
    next_ctrl = ctrl;
    next_cmd = cmd;
    next_clr = '0;
    next_wr_acc = 1'b0;
    next_wr_val = wr_val;
    next_pre_val = pre_val;
    next_home_pos = home_pos;
    next_pset = pset;
    wval = '0;
    if (rsp.bvalid & axi_req_i.bready)
      next_rsp.bvalid = 1'b0;
    if (next_aw_got & next_w_got & ~rsp.bvalid)
    begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_rsp.bvalid = 1'b1;
      next_rsp.bresp = 2'b00;
      if (next_waddr == `OFF_CTRL)
        next_ctrl = merge(ctrl, next_wdat, next_wstb);
      else if (next_waddr == `OFF_CMD)
      begin
        wval = merge({23'h0, cmd, 7'h0}, next_wdat, next_wstb);
        // clear pulses only act when the low byte is strobed
        next_clr = next_wstb[0] ? wval[6:0] : 7'h0;
        next_cmd = wval[`CMD_HOME:`CMD_OUT_EN];
      end
      else if (next_waddr == `OFF_ACC)
      begin
        next_wr_acc = 1'b1;
        next_wr_val = merge(acc, next_wdat, next_wstb);
      end
      else if (next_waddr == `OFF_PRE0 || next_waddr == `OFF_PRE1)
        next_pre_val[next_waddr[2]] = merge(pre_val[next_waddr[2]], next_wdat, next_wstb);
      else if (next_waddr == `OFF_HOME)
        next_home_pos = merge(home_pos, next_wdat, next_wstb);
      else if (next_waddr >= `OFF_PSET0 && next_waddr <= `OFF_PSET7 && next_waddr[1:0] == 2'b00)
        next_pset[3'((next_waddr - `OFF_PSET0) >> 2)] =
          merge(pset[3'((next_waddr - `OFF_PSET0) >> 2)], next_wdat, next_wstb);
      else if (next_waddr != `OFF_STAT && next_waddr != `OFF_CPT &&
               !(next_waddr >= `OFF_STRB0 && next_waddr <= `OFF_STRB2 && next_waddr[1:0] == 2'b00))
        next_rsp.bresp = 2'b10;
    end
    next_rsp.awready = ~next_aw_got & ~next_rsp.bvalid;
    next_rsp.wready = ~next_w_got & ~next_rsp.bvalid;
    if (rsp.rvalid & axi_req_i.rready)
      next_rsp.rvalid = 1'b0;
    if (axi_req_i.arvalid & rsp.arready)
    begin
      next_rsp.rvalid = 1'b1;
      next_rsp.rdata = rd;
      next_rsp.rresp = rd_err ? 2'b10 : 2'b00;
    end
    next_rsp.arready = ~next_rsp.rvalid;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rsp <= '0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      waddr <= '0;
      wdat <= '0;
      wstb <= '0;
      ctrl <= `RST_WORD;
      cmd <= '0;
      clr <= '0;
      wr_acc <= 1'b0;
      wr_val <= '0;
      pre_val <= '{default: '0};
      home_pos <= `RST_WORD;
      pset <= '{default: '0};
    end
    else
    begin
      rsp <= next_rsp;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      waddr <= next_waddr;
      wdat <= next_wdat;
      wstb <= next_wstb;
      ctrl <= next_ctrl;
      cmd <= next_cmd;
      clr <= next_clr;
      wr_acc <= next_wr_acc;
      wr_val <= next_wr_val;
      pre_val <= next_pre_val;
      home_pos <= next_home_pos;
      pset <= next_pset;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_capture_copy: assert property (
    strb_ev[0] |=> strb[0] == $past(acc) && flg_cap[0])
    else $error("capture 0 not latched");
  a_home_load: assert property (
    home_ev |=> acc == $past(home_pos) && home_found)
    else $error("home position not loaded");
  a_home_once: assert property (
    home_ev |=> !home_ev ##1 (!home_ev || !filt[5]))
    else $error("second home load without re-arm");
  a_preload_prio: assert property (
    (rise[10] && rise[11] && !home_ev && win_cnt == '0)
    |=> acc == $past(pre_val[0]) && flg_pre[0])
    else $error("preload priority broken");
  a_window_block: assert property (
    (win_cnt != '0 && win_rank == 2'd3) |-> pre_ev == 2'b00)
    else $error("preload inside home window");
  a_inhibit_hold: assert property (
    (filt[4] && !ld && !wr_acc) |=> acc == $past(acc) && cpt == '0)
    else $error("count while inhibited");
  a_updown_up: assert property (
    (ctrl[1:0] == 2'b00 && rise[0] && !rise[1] && sm == 2'sd0 && !filt[4] && !ld && !wr_acc)
    |=> acc == $past(acc) + 32'd1)
    else $error("up edge did not increment");
  a_minus_sign: assert property (
    (sp == 2'sd0 && sm == 2'sd1 && !filt[4] && !ld && !wr_acc) |=> acc == $past(acc) - 32'd1)
    else $error("minus loop sign wrong");
  a_flag_sticky: assert property (
    $fell(flg_cap[0]) |-> $past(clr[0]))
    else $error("capture flag dropped without clear");
  a_out_gate: assert property (
    !cmd[0] |=> preset_out_o == 4'h0)
    else $error("output on while disabled");
endmodule

// ### dqc_map.svh
`ifndef DQC_MAP_SVH
`define DQC_MAP_SVH

// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_CMD 8'h04
`define OFF_STAT 8'h08
`define OFF_ACC 8'h0c
`define OFF_CPT 8'h10
`define OFF_STRB0 8'h14
`define OFF_STRB2 8'h1c
`define OFF_PRE0 8'h20
`define OFF_PRE1 8'h24
`define OFF_HOME 8'h28
`define OFF_PSET0 8'h30
`define OFF_PSET7 8'h4c

// control register fields
`define CTL_PMODE 0
`define CTL_MMODE 2
`define CTL_FLT_P 4
`define CTL_FLT_M 5
`define CTL_FLT_INH 6
`define CTL_FLT_PRE 7
`define CTL_POL 8

// command register fields
`define CMD_CLR_CAP 0
`define CMD_CLR_PRE 3
`define CMD_CLR_ERR 5
`define CMD_CLR_HOME 6
`define CMD_OUT_EN 7
`define CMD_HOME 8

`define RST_WORD 32'h0000_0000

// timing
`define CLK_PS 8000
`define CLK_MHZ 125
`define FAST_FILT_PS 2500
`define SLOW_FILT_US 12500
`define PRIO_WIN_US 500
`define TB_MS 1000
`define FAST_CYC ((`FAST_FILT_PS + `CLK_PS - 1) / `CLK_PS)
`define SLOW_CYC (`SLOW_FILT_US * `CLK_MHZ)
`define PRIO_CYC (`PRIO_WIN_US * `CLK_MHZ)
`define TB_CYC (`TB_MS * 1000 * `CLK_MHZ)

`endif

// ### dqc_pkg.sv
package dqc_pkg;
  localparam int AW = 8;

  typedef enum logic [1:0] {MODE_UPDN, MODE_PDIR, MODE_QUAD} count_mode_t;

  typedef struct packed {
    logic [AW-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axi_rsp_t;
endpackage

// ### dqc_field_model.sv
`timescale 1ns/10ps
module dqc_field_model (
  input wire logic sys_clk_i,
  output logic [1:0] phase_one_o,
  output logic [1:0] phase_two_o,
  output logic [7:0] line_o
);
  initial
  begin
    phase_one_o = '0;
    phase_two_o = '0;
    line_o = '0;
  end
  // each level is held four clocks so sync, filter and edge detect all see it
  task automatic step(input int lp, input logic a, input logic b);
    @(posedge sys_clk_i);
    phase_one_o[lp] <= a;
    phase_two_o[lp] <= b;
    repeat (3) @(posedge sys_clk_i);
  endtask
  // lines: 0 inhibit, 1 home enable, 2 index, 5:3 captures, 7:6 preloads
  task automatic set_line(input int i, input logic v);
    @(posedge sys_clk_i);
    line_o[i] <= v;
    repeat (3) @(posedge sys_clk_i);
  endtask
  // two lines moved on one edge, for loads that race each other
  task automatic set_pair(input int i, input int j, input logic v);
    @(posedge sys_clk_i);
    line_o[i] <= v;
    line_o[j] <= v;
    repeat (3) @(posedge sys_clk_i);
  endtask
  // a high pulse of n clocks, shorter than the slow filter time
  task automatic glitch(input int i, input int n);
    @(posedge sys_clk_i);
    line_o[i] <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
    line_o[i] <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask
  // kind 0 up/down, 1 pulse/sense, 2 quadrature; dn picks the downward sense
  task automatic count(input int lp, input int kind, input logic dn, input int n);
    repeat (n)
    begin
      case (kind)
        0:
        begin
          step(lp, !dn, dn);
          step(lp, 1'b0, 1'b0);
        end
        1:
        begin
          step(lp, 1'b0, dn); // sense settles before the pulse rises
          step(lp, 1'b1, dn);
          step(lp, 1'b0, dn);
        end
        default:
        begin
          step(lp, !dn, dn);
          step(lp, 1'b1, 1'b1);
          step(lp, dn, !dn);
          step(lp, 1'b0, 1'b0);
        end
      endcase
    end
    step(lp, 1'b0, 1'b0);
  endtask
endmodule

// ### test_differential_quadrature_counter.sv
`timescale 1ns/10ps
module test_differential_quadrature_counter;
  typedef struct {
    logic [31:0] ctrl;
    int lp;
    int kind;
    logic dn;
    int n;
    logic [31:0] exp;
  } row_t;
  logic sys_clk;
  logic rst_n;
  dqc_pkg::axi_req_t req;
  dqc_pkg::axi_rsp_t rsp;
  logic [1:0] ph1;
  logic [1:0] ph2;
  logic [7:0] ln;
  logic [3:0] pout;
  logic [31:0] rd;
  logic [1:0] rs;
  int err_count;
  int cmp_count;
  row_t rows [10] = '{
    '{32'h0c, 0, 0, 1'b0, 3, 32'h3}, '{32'h0c, 0, 0, 1'b1, 2, 32'hffff_fffe},
    '{32'h0d, 0, 1, 1'b0, 3, 32'h3}, '{32'h0d, 0, 1, 1'b1, 2, 32'hffff_fffe},
    '{32'h0e, 0, 2, 1'b0, 2, 32'h8}, '{32'h0e, 0, 2, 1'b1, 1, 32'hffff_fffc},
    '{32'h03, 1, 0, 1'b0, 3, 32'hffff_fffd}, '{32'h0b, 1, 2, 1'b0, 1, 32'hffff_fffc},
    '{32'h07, 1, 1, 1'b1, 2, 32'h2}, '{32'h0f, 0, 0, 1'b0, 2, 32'h0}};

  dqc_field_model fm (
    .sys_clk_i(sys_clk),
    .phase_one_o(ph1),
    .phase_two_o(ph2),
    .line_o(ln)
  );
  differential_quadrature_counter #(.SLOW_CYC(4), .PRIO_CYC(8), .TB_CYC(16)) uut (
    .sys_clk_i(sys_clk),
    .rst_n_i(rst_n),
    .axi_req_i(req),
    .axi_rsp_o(rsp),
    .plus_loop_phase_one_i(ph1[0]),
    .plus_loop_phase_two_i(ph2[0]),
    .minus_loop_phase_one_i(ph1[1]),
    .minus_loop_phase_two_i(ph2[1]),
    .count_inhibit_i(ln[0]),
    .home_enable_i(ln[1]),
    .index_pulse_i(ln[2]),
    .capture_i(ln[5:3]),
    .preload_i(ln[7:6]),
    .preset_out_o(pout)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d); // bus stands for the scan
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!done)
    begin
      @(posedge sys_clk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1)
      begin
        rs = rsp.bresp;
        req.bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rdr(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    while (!done)
    begin
      @(posedge sys_clk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1)
      begin
        rd = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic acc_is(input logic [31:0] exp);
    idle(8);
    rdr(8'h0c);
    chk(rd, exp);
  endtask

  initial
  begin
    #320000;
    err_count++;
    close_out();
  end

  initial
  begin
    req = '0;
    rst_n = 1'b0;
    err_count = 0;
    cmp_count = 0;
    idle(6);
    rst_n <= 1'b1;
    idle(2);
    foreach (rows[i])
    begin
      wr(8'h00, rows[i].ctrl);
      wr(8'h0c, 32'h0);
      fm.count(rows[i].lp, rows[i].kind, rows[i].dn, rows[i].n);
      acc_is(rows[i].exp);
    end
    // second reset in mid-run
    @(posedge sys_clk);
    rst_n <= 1'b0;
    idle(6);
    rst_n <= 1'b1;
    idle(2);
    rdr(8'h00);
    chk(rd, 32'h0);
    rdr(8'h08);
    chk(rd, 32'h1000);
    wr(8'h2c, 32'h1);
    chk({30'h0, rs}, 32'h2);
    rdr(8'h02);
    chk({rd[29:0], rs}, 32'h2);
    // capture 1 on falling edge, the others on rising
    wr(8'h00, 32'h200);
    wr(8'h0c, 32'h1234);
    for (int i = 3; i < 6; i++)
      fm.set_line(i, 1'b1);
    wr(8'h0c, 32'h5678);
    for (int i = 3; i < 6; i++)
      fm.set_line(i, 1'b0);
    idle(8);
    for (int i = 0; i < 3; i++)
    begin
      rdr(8'h14 + 8'(4 * i));
      chk(rd, (i == 1) ? 32'h5678 : 32'h1234);
    end
    wr(8'h0c, 32'h9);
    fm.set_line(3, 1'b1);
    fm.set_line(3, 1'b0);
    idle(8);
    rdr(8'h14);
    chk(rd, 32'h9);
    rdr(8'h08);
    chk(rd & 32'h7, 32'h7);
    wr(8'h04, 32'h7);
    rdr(8'h08);
    chk(rd & 32'h7, 32'h0);
    // preloads: value, rising edge only, reload while flagged, priority
    wr(8'h20, 32'd100);
    wr(8'h24, 32'd200);
    fm.set_line(7, 1'b1);
    acc_is(32'd200);
    wr(8'h0c, 32'h7);
    fm.set_line(7, 1'b0);
    acc_is(32'h7);
    fm.set_line(7, 1'b1);
    acc_is(32'd200);
    fm.set_line(7, 1'b0);
    idle(12);
    fm.set_line(6, 1'b1);
    fm.set_line(7, 1'b1);
    acc_is(32'd100);
    fm.set_line(6, 1'b0);
    fm.set_line(7, 1'b0);
    idle(12);
    fm.set_line(7, 1'b1);
    fm.set_line(6, 1'b1);
    acc_is(32'd100);
    fm.set_line(6, 1'b0);
    fm.set_line(7, 1'b0);
    idle(12);
    wr(8'h0c, 32'h0);
    fm.set_pair(6, 7, 1'b1);
    acc_is(32'h64);
    fm.set_pair(6, 7, 1'b0);
    wr(8'h04, 32'h18);
    rdr(8'h08);
    chk(rd & 32'h18, 32'h0);
    // homing: command first, then enable held until the index arrives
    wr(8'h28, 32'h777);
    wr(8'h04, 32'h100);
    fm.set_line(1, 1'b1);
    idle(12);
    rdr(8'h08);
    chk(rd & 32'h80, 32'h80);
    wr(8'h0c, 32'h5);
    fm.set_line(2, 1'b1);
    fm.set_line(2, 1'b0);
    acc_is(32'h777);
    rdr(8'h08);
    chk(rd & 32'h20, 32'h20);
    wr(8'h0c, 32'h5);
    fm.set_line(2, 1'b1);
    fm.set_line(2, 1'b0);
    acc_is(32'h5);
    fm.set_line(1, 1'b0);
    fm.set_line(1, 1'b1);
    idle(12);
    fm.set_line(6, 1'b1);
    fm.set_line(2, 1'b1);
    acc_is(32'h777);
    fm.set_line(2, 1'b0);
    fm.set_line(6, 1'b0);
    fm.set_line(1, 1'b0);
    // preload arriving inside the home window must be dropped
    fm.set_line(1, 1'b1);
    idle(12);
    wr(8'h0c, 32'h5);
    fm.set_line(2, 1'b1);
    fm.set_line(6, 1'b1);
    acc_is(32'h777);
    fm.set_line(2, 1'b0);
    fm.set_line(6, 1'b0);
    fm.set_line(1, 1'b0);
    wr(8'h04, 32'h40);
    rdr(8'h08);
    chk(rd & 32'h20, 32'h0);
    // inhibit is a level that blocks counting
    wr(8'h00, 32'h0c);
    wr(8'h0c, 32'h0);
    fm.set_line(0, 1'b1);
    idle(8);
    fm.count(0, 0, 1'b0, 3);
    acc_is(32'h0);
    rdr(8'h10);
    chk(rd, 32'h0);
    rdr(8'h08);
    chk(rd & 32'h40, 32'h40);
    fm.set_line(0, 1'b0);
    idle(8);
    fm.count(0, 0, 1'b0, 1);
    acc_is(32'h1);
    // preset window 10..19 on output 0, both bounds probed
    wr(8'h30, 32'd10);
    wr(8'h34, 32'd20);
    wr(8'h04, 32'h80);
    wr(8'h0c, 32'd15);
    idle(4);
    chk({28'h0, pout}, 32'h1);
    wr(8'h0c, 32'd20);
    idle(4);
    chk({28'h0, pout}, 32'h0);
    wr(8'h0c, 32'd10);
    idle(4);
    chk({28'h0, pout}, 32'h1);
    rdr(8'h08);
    chk(rd & 32'hf00, 32'h100);
    // short preload pulse: slow filter swallows it, fast filter passes it
    wr(8'h00, 32'h8c);
    wr(8'h0c, 32'h3);
    fm.glitch(6, 2);
    acc_is(32'h3);
    wr(8'h00, 32'h0c);
    fm.glitch(6, 2);
    acc_is(32'h64);
    // signed overflow raises the error flag until cleared
    wr(8'h0c, 32'h7fff_ffff);
    fm.count(0, 0, 1'b0, 1);
    rdr(8'h08);
    chk(rd & 32'h2000, 32'h2000);
    wr(8'h04, 32'h20);
    rdr(8'h08);
    chk(rd & 32'h2000, 32'h0);
    close_out();
  end
endmodule
